/* File: nibble_data_memory_map.sv */
// data-memory decoder, special-function registers and paged sram
// assumes the core issues one access per cycle: addr, op, operand, bit index
module nibble_data_memory_map #(
   parameter int sram_nibbles = 128,
   parameter int page_bits    = 2
) (
   input  wire logic       clk,          // system clock
   input  wire logic       rst_n,        // synchronous reset
   input  wire logic       acc_valid,    // core access this cycle
   input  wire logic [5:0] acc_addr,     // direct address
   input  wire logic [3:0] acc_op,       // alu_op_t operation code
   input  wire logic [3:0] acc_operand,  // immediate or accumulator operand
   input  wire logic [1:0] acc_bit,      // bit index for set and clear
   input  wire logic       acc_indirect, // access came via indirect addressing
   input  wire logic       page_load,    // load page select instruction
   input  wire logic [1:0] page_value,   // value for page select
   output logic [3:0]      rd_data,      // registered read/result data
   output logic            rd_valid,     // rd_data valid pulse
   output logic [3:0]      flags,        // flag register contents
   input  wire logic       pwm_irq_set,  // pwm engine raises its flag
   input  wire logic       opt_bidir,    // bidirectional port option
   input  wire logic       opt_ten_bit,  // ten-bit resolution option
   input  wire logic       opt_twelve,   // twelve-bit resolution option
   input  wire logic [3:0] pa_in,        // port a pin levels
   output logic [3:0]      pa_out,       // port a output latch
   output logic [3:0]      pa_oe_n,      // port a enable, low drives
   input  wire logic [3:0] pb_in,        // port b pin levels
   output logic [3:0]      pb_out,       // port b output latch
   output logic [3:0]      pb_oe_n,      // port b enable, low drives
   input  wire logic [3:0] pce_in,       // combo port pin levels
   output logic [3:0]      pce_out,      // port c / combo output latch
   output logic [3:0]      pce_oe_n,     // combo port enable, low drives
   output logic [11:0]     pwm_sample,   // assembled pwm sample
   output logic            pwm_sign,     // sample sign, 0 positive
   input  wire logic       rom_req,      // data-rom read request
   input  wire logic [7:0] rom_raw,      // data-rom array output
   output logic [7:0]      rom_data,     // data-rom read data
   output logic            rom_ready     // rom_data valid pulse
);
   localparam int page_words = sram_nibbles / (1 << page_bits);
   localparam int sram_idx   = $clog2(sram_nibbles);
   // refuse geometries the page decode cannot serve
   if (page_bits != 2 || sram_nibbles < 32 || sram_nibbles > 128) begin : g_bad_geometry
      $error("unsupported sram geometry");
   end

   // sram array, never reset; see [RULE_01] see [RULE_04]
   logic [3:0] sram_q [sram_nibbles];
   logic [1:0] page_q, page_d;
   logic [3:0] flags_q, flags_d, cdir_q, cdir_d, adir_q, adir_d, bdir_q, bdir_d;
   logic [3:0] alat_q, alat_d, blat_q, blat_d, clat_q, clat_d;
   logic [3:0] usr1_q, usr1_d, usr2_q, usr2_d;
   logic [3:0] lsb_q, lsb_d, low_q, low_d, high_q, high_d;
   logic [3:0] rd_q, rd_d;
   logic       rdv_q;
   logic [3:0] pa_lvl, pb_lvl, pce_lvl;
   logic [3:0] cur, res;
   logic       carry_n, zero_n, wr_en, sram_we, sfr_sel;
   logic [sram_idx-1:0] sram_a;
   logic [1:0] rom_cnt_q, rom_cnt_d;
   logic [7:0] rom_q, rom_d;
   logic       rom_vld_q, rom_vld_d;

   pin_sync #(.width(4)) u_sync_a (.clk(clk), .rst_n(rst_n), .pin_i(pa_in),  .level(pa_lvl));
   pin_sync #(.width(4)) u_sync_b (.clk(clk), .rst_n(rst_n), .pin_i(pb_in),  .level(pb_lvl));
   pin_sync #(.width(4)) u_sync_c (.clk(clk), .rst_n(rst_n), .pin_i(pce_in), .level(pce_lvl));

   // decode an address into the register block
   function automatic logic is_sfr(input logic [5:0] a);
      return a < mem_map_pkg::addr_sram_base; // see [RULE_03]
   endfunction : is_sfr

   assign sfr_sel = is_sfr(acc_addr);
   assign sram_a  = sram_idx'({page_q, acc_addr[4:0]}); // see [RULE_04]

   // current operand value read from the addressed location
   always_comb begin
      cur = 4'h0;
      if (!sfr_sel) begin
         cur = sram_q[sram_a];
      end else begin
         unique case (acc_addr)
            mem_map_pkg::addr_flags:     cur = flags_q;
            mem_map_pkg::addr_combo_dir: cur = cdir_q;
            mem_map_pkg::addr_pa_dir:    cur = adir_q;
            mem_map_pkg::addr_pa_val:    cur = pa_lvl;  // see [RULE_12]
            mem_map_pkg::addr_pc_out:    cur = opt_bidir ? pce_lvl : clat_q;
            mem_map_pkg::addr_pb_dir:    cur = bdir_q;
            mem_map_pkg::addr_pb_val:    cur = pb_lvl;  // see [RULE_13]
            mem_map_pkg::addr_scratch1:  cur = usr1_q;  // see [RULE_15]
            mem_map_pkg::addr_scratch2:  cur = usr2_q;  // see [RULE_05]
            default:                     cur = 4'h0;    // see [RULE_20]
         endcase
      end
   end

   // alu on any location, same set for every register
   always_comb begin
      logic [4:0] sum;
      sum     = 5'h00;
      res     = cur;
      wr_en   = 1'b1;
      carry_n = flags_q[mem_map_pkg::bit_carry];
      unique case (mem_map_pkg::alu_op_t'(acc_op)) // see [RULE_06]
         mem_map_pkg::op_ld:  begin res = cur; wr_en = 1'b0; end
         mem_map_pkg::op_st:  res = acc_operand;
         mem_map_pkg::op_adc: begin
            sum = {1'b0, cur} + {1'b0, acc_operand} + {4'h0, flags_q[mem_map_pkg::bit_carry]};
            res = sum[3:0]; carry_n = sum[4];
         end
         mem_map_pkg::op_adr: begin
            sum = {1'b0, cur} + {1'b0, acc_operand};
            res = sum[3:0]; carry_n = sum[4];
         end
         mem_map_pkg::op_sbc: begin
            sum = {1'b0, cur} - {1'b0, acc_operand} - {4'h0, ~flags_q[mem_map_pkg::bit_carry]};
            res = sum[3:0]; carry_n = ~sum[4];
         end
         mem_map_pkg::op_cmp: begin
            sum = {1'b0, cur} - {1'b0, acc_operand};
            res = sum[3:0]; carry_n = ~sum[4]; wr_en = 1'b0;
         end
         mem_map_pkg::op_or:  res = cur | acc_operand;
         mem_map_pkg::op_and: res = cur & acc_operand;
         mem_map_pkg::op_xor: res = cur ^ acc_operand;
         mem_map_pkg::op_inc: begin sum = {1'b0, cur} + 5'h01; res = sum[3:0]; carry_n = sum[4]; end
         mem_map_pkg::op_dec: begin sum = {1'b0, cur} - 5'h01; res = sum[3:0]; carry_n = ~sum[4]; end
         mem_map_pkg::op_rlc: begin res = {cur[2:0], flags_q[mem_map_pkg::bit_carry]}; carry_n = cur[3]; end
         mem_map_pkg::op_rrc: begin res = {flags_q[mem_map_pkg::bit_carry], cur[3:1]}; carry_n = cur[0]; end
         mem_map_pkg::op_bset, mem_map_pkg::op_bclr: begin
            res = cur;
            res[acc_bit] = (mem_map_pkg::alu_op_t'(acc_op) == mem_map_pkg::op_bset);
            wr_en = acc_indirect || (acc_addr <= mem_map_pkg::addr_bit_limit); // see [RULE_07]
         end
         mem_map_pkg::op_nop: wr_en = 1'b0;
      endcase
      zero_n = (res == 4'h0);
   end

   assign sram_we = acc_valid && wr_en && !sfr_sel;

   // next values of the register block
   always_comb begin
      logic bitop;
      bitop   = (acc_op == 4'(mem_map_pkg::op_bset)) || (acc_op == 4'(mem_map_pkg::op_bclr));
      page_d  = page_load ? page_value : page_q; // see [RULE_02]
      flags_d = flags_q;
      cdir_d  = cdir_q;
      adir_d  = adir_q;
      bdir_d  = bdir_q;
      alat_d  = alat_q;
      blat_d  = blat_q;
      clat_d  = clat_q;
      usr1_d  = usr1_q;
      usr2_d  = usr2_q;
      lsb_d   = lsb_q;
      low_d   = low_q;
      high_d  = high_q;
      rd_d    = acc_valid ? res : rd_q;
      if (acc_valid && !bitop && acc_op != 4'(mem_map_pkg::op_st)
          && acc_op != 4'(mem_map_pkg::op_nop)) begin
         flags_d[mem_map_pkg::bit_carry] = carry_n; // see [RULE_08]
         flags_d[mem_map_pkg::bit_zero]  = zero_n;
      end
      if (acc_valid && wr_en && sfr_sel) begin
         unique case (acc_addr)
            mem_map_pkg::addr_flags:     flags_d = {1'b0, res[2:0]};
            mem_map_pkg::addr_combo_dir: cdir_d  = res; // see [RULE_11]
            mem_map_pkg::addr_pa_dir:    adir_d  = res; // see [RULE_09]
            mem_map_pkg::addr_pa_val:    alat_d  = res; // see [RULE_12]
            mem_map_pkg::addr_pc_out:    clat_d  = res; // see [RULE_14]
            mem_map_pkg::addr_pb_dir:    bdir_d  = res; // see [RULE_10]
            mem_map_pkg::addr_pb_val:    blat_d  = res; // see [RULE_13]
            mem_map_pkg::addr_scratch1:  usr1_d  = res; // see [RULE_15]
            mem_map_pkg::addr_pwm_lsb:   lsb_d   = res; // see [RULE_16]
            mem_map_pkg::addr_pwm_low:   low_d   = res;
            mem_map_pkg::addr_pwm_high:  high_d  = res;
            mem_map_pkg::addr_scratch2:  usr2_d  = res; // see [RULE_05]
            default: ;
         endcase
      end
      // hardware set wins over a clear in the same cycle
      if (pwm_irq_set) flags_d[mem_map_pkg::bit_pwm_irq] = 1'b1;
      flags_d[3] = 1'b0;
   end

   // data-rom read with two-cycle ready
   always_comb begin
      rom_d     = rom_q;
      rom_cnt_d = rom_cnt_q;
      rom_vld_d = 1'b0;
      if (rom_req) begin
         rom_cnt_d = 2'(mem_map_pkg::rom_ready_cyc - 1);
      end else if (rom_cnt_q != 2'd0) begin
         rom_cnt_d = rom_cnt_q - 2'd1;
         if (rom_cnt_q == 2'd1) begin
            rom_d     = rom_raw; // see [RULE_18]
            rom_vld_d = 1'b1;
         end
      end
   end

   // register everything; sram and undefined-reset registers keep no reset
   always_ff @(posedge clk) begin
      if (sram_we) sram_q[sram_a] <= res; // see [RULE_04]
      page_q <= page_d;
      usr1_q <= usr1_d;
      usr2_q <= usr2_d;
      lsb_q  <= lsb_d;
      low_q  <= low_d;
      high_q <= high_d;
      alat_q <= alat_d;
      blat_q <= blat_d;
      rd_q   <= rd_d;
      rom_q  <= rom_d;
      if (!rst_n) begin
         flags_q   <= mem_map_pkg::rst_flags;
         cdir_q    <= mem_map_pkg::rst_dir;
         adir_q    <= mem_map_pkg::rst_dir;
         bdir_q    <= mem_map_pkg::rst_dir;
         clat_q    <= mem_map_pkg::rst_pc_out;
         rdv_q     <= 1'b0;
         rom_cnt_q <= 2'd0;
         rom_vld_q <= 1'b0;
      end else begin
         flags_q   <= flags_d;
         cdir_q    <= cdir_d;
         adir_q    <= adir_d;
         bdir_q    <= bdir_d;
         clat_q    <= clat_d;
         rdv_q     <= acc_valid;
         rom_cnt_q <= rom_cnt_d;
         rom_vld_q <= rom_vld_d;
      end
   end

   // pin drive: enable low where direction bit is 1
   assign pa_out   = alat_q;
   assign pa_oe_n  = ~adir_q;                               // see [RULE_09]
   assign pb_out   = blat_q;
   assign pb_oe_n  = ~bdir_q;                               // see [RULE_10]
   assign pce_out  = clat_q;                                // see [RULE_14]
   assign pce_oe_n = opt_bidir ? ~cdir_q : 4'h0;            // see [RULE_11]

   // sample assembly by resolution option
   always_comb begin
      if (opt_twelve) pwm_sample = {high_q, low_q, lsb_q};               // see [RULE_17]
      else if (opt_ten_bit) pwm_sample = {2'b00, high_q, low_q, lsb_q[3:2]}; // see [RULE_16]
      else pwm_sample = {4'h0, high_q, low_q};
   end
   assign pwm_sign  = high_q[3]; // see [RULE_19]

   assign rd_data   = rd_q;
   assign rd_valid  = rdv_q;
   assign flags     = flags_q;
   assign rom_data  = rom_q;
   assign rom_ready = rom_vld_q; // see [RULE_18]
endmodule : nibble_data_memory_map

/* File: mem_map_pkg.sv */
// constants for the nibble data-memory decoder and its register file
// assumes a 4-bit core issuing direct addresses of 6 bits on one clock
// Function
// [RULE_01] 128 nibbles of user sram split into pages by a 2-bit page select
// [RULE_02] software loads page select before using sram; reset leaves it undefined
// [RULE_03] addresses 00h to 1fh always reach the 32-nibble register block
// [RULE_04] addresses 20h to 3fh reach sram in the selected page; no sram reset
// [RULE_05] the two extra nibbles are two scratch registers, not sram
// [RULE_06] every register accepts all arithmetic, logic, rotate and compare operations
// [RULE_07] direct bit set and clear act only on addresses 00h to 0fh
// [RULE_08] flags at 00h: pwm irq bit 2, carry bit 1, zero bit 0
// [RULE_09] port a direction at 02h, 1 output, resets to 0000
// [RULE_10] port b direction at 05h, 1 output, resets to 0000
// [RULE_11] combo direction at 01h acts only with bidirectional option, resets 0000
// [RULE_12] port a data at 03h reads pins, writes the output latch
// [RULE_13] port b data at 06h reads pins, writes the output latch
// [RULE_14] register 04h drives output-only port c; latch resets to 0000
// [RULE_15] address 07h is a read/write scratch nibble, reset undefined
// [RULE_16] ten-bit mode: bits 3:2 of 08h give sample bits 1:0
// [RULE_17] twelve-bit mode: all bits of 08h give sample bits 3:0
// [RULE_18] data-rom read data is ready within two system clocks
// [RULE_19] top bit of the high sample nibble is the sign, 0 positive
// [RULE_20] reading the write-only low-bits register returns junk, no side effect
package mem_map_pkg;
   localparam logic [5:0] addr_flags      = 6'h00;
   localparam logic [5:0] addr_combo_dir  = 6'h01;
   localparam logic [5:0] addr_pa_dir     = 6'h02;
   localparam logic [5:0] addr_pa_val     = 6'h03;
   localparam logic [5:0] addr_pc_out     = 6'h04;
   localparam logic [5:0] addr_pb_dir     = 6'h05;
   localparam logic [5:0] addr_pb_val     = 6'h06;
   localparam logic [5:0] addr_scratch1   = 6'h07;
   localparam logic [5:0] addr_pwm_lsb    = 6'h08;
   localparam logic [5:0] addr_pwm_low    = 6'h0A;
   localparam logic [5:0] addr_pwm_high   = 6'h0B;
   localparam logic [5:0] addr_scratch2   = 6'h0F;
   localparam logic [5:0] addr_sram_base  = 6'h20;
   localparam logic [5:0] addr_bit_limit  = 6'h0F;
   localparam int         bit_zero        = 0;
   localparam int         bit_carry       = 1;
   localparam int         bit_pwm_irq     = 2;
   localparam logic [3:0] rst_dir         = 4'h0;
   localparam logic [3:0] rst_pc_out      = 4'h0;
   localparam logic [3:0] rst_flags       = 4'h0;
   localparam logic [3:0] rst_free        = 4'h0;
   localparam int         rom_ready_cyc   = 2;
   localparam int         pin_sync_stages = 3;
   typedef enum logic [3:0] {
      op_ld, op_adc, op_sbc, op_or, op_and, op_xor,
      op_inc, op_dec, op_rlc, op_rrc, op_cmp, op_adr,
      op_bset, op_bclr, op_st, op_nop
   } alu_op_t;
endpackage : mem_map_pkg

/* File: pin_sync.sv */
// three-stage synchroniser with agreement filter for a group of pins
// assumes pins are asynchronous to clk; output changes once stages 2 and 3 agree
module pin_sync #(
   parameter int width = 4
) (
   input  wire logic             clk,   // system clock
   input  wire logic             rst_n, // synchronous reset
   input  wire logic [width-1:0] pin_i, // raw pin levels
   output logic      [width-1:0] level  // filtered level
);
   logic [width-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [width-1:0] lvl_d;

   // accept a new value only where the last two stages agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < width; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   // register the chain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;
endmodule : pin_sync

/* File: nibble_data_memory_map_asserts.sv */
// concurrent checks on the ports of the data-memory map
// assumes one clock domain; bound to every instance of the map
module nibble_data_memory_map_asserts (
   input wire logic        clk,          // system clock
   input wire logic        rst_n,        // synchronous reset
   input wire logic        acc_valid,    // core access
   input wire logic [5:0]  acc_addr,     // direct address
   input wire logic [3:0]  acc_op,       // operation code
   input wire logic        acc_indirect, // indirect access
   input wire logic        rd_valid,     // result pulse
   input wire logic [3:0]  flags,        // flag register
   input wire logic        pwm_irq_set,  // pwm flag request
   input wire logic        opt_bidir,    // bidirectional option
   input wire logic        opt_ten_bit,  // ten-bit option
   input wire logic        opt_twelve,   // twelve-bit option
   input wire logic [3:0]  pa_oe_n,      // port a enables
   input wire logic [3:0]  pb_oe_n,      // port b enables
   input wire logic [3:0]  pce_out,      // port c latch
   input wire logic [3:0]  pce_oe_n,     // combo enables
   input wire logic [11:0] pwm_sample,   // assembled sample
   input wire logic        rom_req,      // rom request
   input wire logic [7:0]  rom_raw,      // rom array data
   input wire logic [7:0]  rom_data,     // rom read data
   input wire logic        rom_ready     // rom data valid pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // every access answers exactly one cycle later
   access_answer_a: assert property (rd_valid == $past(acc_valid))
      else $error("result pulse does not follow access");
   // pwm engine request lands in bit 2
   irq_flag_set_a: assert property (pwm_irq_set |=> flags[2])
      else $error("pwm flag not set");
   // reserved flag bit stays clear
   flag_reserved_a: assert property (flags[3] == 1'b0)
      else $error("reserved flag bit set");
   // reset leaves flags clear, ports a and b as inputs, port c low
   reset_values_a: assert property (!$past(rst_n) |-> flags == 4'h0 && pa_oe_n == 4'hf
      && pb_oe_n == 4'hf && pce_out == 4'h0) else $error("bad reset values");
   // without the bidirectional option port c always drives
   port_c_drive_a: assert property (!opt_bidir && !$past(opt_bidir) |-> pce_oe_n == 4'h0)
      else $error("port c not driven");
   // ten-bit sample leaves the top two bits clear
   ten_bit_top_a: assert property (opt_ten_bit && !opt_twelve |-> pwm_sample[11:10] == 2'b00)
      else $error("ten-bit sample too wide");
   // eight-bit sample leaves the top nibble clear
   eight_bit_top_a: assert property (!opt_ten_bit && !opt_twelve |-> pwm_sample[11:8] == 4'h0)
      else $error("eight-bit sample too wide");
   // rom data holds the request-cycle rom value three cycles after the request
   rom_ready_time_a: assert property (rom_req ##1 $stable(rom_raw) ##1 $stable(rom_raw)
      |=> rom_data == $past(rom_raw, 3)) else $error("rom data late");
   // ready pulse marks the captured rom data
   rom_ready_pulse_a: assert property (rom_req ##1 !rom_req |=> rom_ready)
      else $error("rom ready missing");
   // direct bit set above 0fh leaves the flags unchanged
   bit_op_range_a: assert property (acc_valid && acc_op == mem_map_pkg::op_bset
      && acc_addr > 6'h0f && !acc_indirect && !pwm_irq_set |=> flags == $past(flags))
      else $error("direct bit op above range acted");
endmodule : nibble_data_memory_map_asserts

bind nibble_data_memory_map nibble_data_memory_map_asserts u_asserts (.*);

/* File: tb.sv */
// self-checking bench for the nibble data-memory map
// assumes one 200 MHz clock; inputs change on the falling edge
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, acc_valid, acc_indirect, page_load, pwm_irq_set, rd_valid;
   logic        opt_bidir, opt_ten_bit, opt_twelve, rom_req, pwm_sign, rom_ready;
   logic [5:0]  acc_addr;
   logic [3:0]  acc_op, acc_operand, pa_in, pb_in, pce_in, rd_data, flags, d, x, l, h;
   logic [3:0]  pa_out, pa_oe_n, pb_out, pb_oe_n, pce_out, pce_oe_n;
   logic [1:0]  acc_bit, page_value;
   logic [11:0] pwm_sample, ps;
   logic [7:0]  rom_raw, rom_data;
   int          miscompares, check_count;
   int          mdl [256];
   mem_map_pkg::alu_op_t ops [5] = '{mem_map_pkg::op_or, mem_map_pkg::op_and,
      mem_map_pkg::op_xor, mem_map_pkg::op_inc, mem_map_pkg::op_dec};

   // unit under test
   nibble_data_memory_map #(.sram_nibbles(128), .page_bits(2)) u_nibble_data_memory_map (.*);

   // free-running clock
   always #2.5 clk = ~clk;

   // reference results of the register operations
   function automatic logic [3:0] alu(input int i, input logic [3:0] a, input logic [3:0] b);
      case (i)
         0: return a | b;
         1: return a & b;
         2: return a ^ b;
         3: return a + 4'h1;
         default: return a - 4'h1;
      endcase
   endfunction : alu

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic [5:0] a, input logic [3:0] op, input logic [3:0] v,
                      input logic [1:0] b, input logic ind);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_addr = a;
      acc_op = op;
      acc_operand = v;
      acc_bit = b;
      acc_indirect = ind;
      @(negedge clk);
      acc_valid = 1'b0;
   endtask : acc

   task automatic st(input logic [5:0] a, input logic [3:0] v);
      acc(a, mem_map_pkg::op_st, v, 2'd0, 1'b0);
   endtask : st

   task automatic ldc(input logic [5:0] a, input logic [3:0] v);
      acc(a, mem_map_pkg::op_ld, 4'h0, 2'd0, 1'b0);
      chk(rd_data, v);
      chk(rd_valid, 1'b1);
   endtask : ldc

   task automatic set_page(input logic [1:0] p);
      @(negedge clk);
      page_load = 1'b1;
      page_value = p;
      @(negedge clk);
      page_load = 1'b0;
   endtask : set_page

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // watchdog against a hung run
   initial begin
      #20us;
      miscompares++;
      conclude();
   end

   // main sequence
   initial begin
      {clk, acc_valid, acc_indirect, page_load, pwm_irq_set, opt_bidir} = '0;
      {opt_ten_bit, opt_twelve, rom_req, acc_addr, acc_op, acc_operand, acc_bit} = '0;
      {pa_in, pb_in, pce_in, page_value, rom_raw} = '0;
      rst_n = 1'b0;
      miscompares = 0;
      check_count = 0;
      void'($urandom(5990));
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk(flags, 4'h0);
      chk(pa_oe_n, 4'hf);
      chk(pb_oe_n, 4'hf);
      chk(pce_out, 4'h0);
      $display("reset test done");
      d = 4'($urandom);
      st(6'h02, d);
      st(6'h05, d ^ 4'hf);
      @(negedge clk);
      chk(pa_oe_n, d ^ 4'hf);
      chk(pb_oe_n, d);
      st(6'h03, d);
      st(6'h06, ~d);
      st(6'h04, d + 4'h3);
      chk(pa_out, d);
      chk(pb_out, d ^ 4'hf);
      chk(pce_out, d + 4'h3);
      pa_in = 4'($urandom);
      pb_in = 4'($urandom);
      pce_in = 4'($urandom);
      opt_bidir = 1'b1;
      st(6'h01, d);
      repeat (6) @(negedge clk);
      chk(pce_oe_n, d ^ 4'hf);
      ldc(6'h03, pa_in);
      ldc(6'h06, pb_in);
      ldc(6'h04, pce_in);
      opt_bidir = 1'b0;
      repeat (2) @(negedge clk);
      chk(pce_oe_n, 4'h0);
      $display("port test done");
      for (int p = 0; p < 4; p++) begin
         set_page(p[1:0]);
         for (int k = 32; k < 64; k += 31) begin
            mdl[p*64+k] = $urandom % 16;
            st(6'(k), 4'(mdl[p*64+k]));
         end
      end
      d = 4'($urandom);
      st(6'h07, d);
      st(6'h0f, ~d);
      for (int p = 0; p < 4; p++) begin
         set_page(p[1:0]);
         for (int k = 32; k < 64; k += 31) begin
            ldc(6'(k), 4'(mdl[p*64+k]));
         end
         ldc(6'h07, d);
         ldc(6'h0f, ~d);
      end
      $display("page test done");
      for (int i = 0; i < 5; i++) begin
         d = 4'($urandom);
         x = 4'($urandom);
         st(6'h07, d);
         acc(6'h07, ops[i], x, 2'd0, 1'b0);
         chk(rd_data, alu(i, d, x));
      end
      st(6'h0f, 4'h0);
      acc(6'h0f, mem_map_pkg::op_bset, 4'h0, 2'd2, 1'b0);
      ldc(6'h0f, 4'h4);
      st(6'h20, 4'h0);
      acc(6'h20, mem_map_pkg::op_bset, 4'h0, 2'd1, 1'b0);
      ldc(6'h20, 4'h0);
      acc(6'h20, mem_map_pkg::op_bset, 4'h0, 2'd1, 1'b1);
      ldc(6'h20, 4'h2);
      $display("operation test done");
      x = 4'($urandom);
      l = 4'($urandom);
      h = 4'($urandom);
      st(6'h08, x);
      st(6'h0a, l);
      st(6'h0b, h);
      for (int m = 0; m < 3; m++) begin
         opt_ten_bit = (m == 1);
         opt_twelve = (m == 2);
         @(negedge clk);
         ps = (m == 2) ? {h, l, x} : (m == 1) ? {2'b00, h, l, x[3:2]} : {4'h0, h, l};
         chk(pwm_sample, ps);
         chk(pwm_sign, h[3]);
      end
      ldc(6'h08, 4'h0);
      chk(pwm_sample, {h, l, x});
      $display("pwm test done");
      for (int r = 0; r < 3; r++) begin
         @(negedge clk);
         rom_raw = 8'($urandom);
         rom_req = 1'b1;
         @(negedge clk);
         rom_req = 1'b0;
         @(negedge clk);
         chk(rom_ready, 1'b1);
         chk(rom_data, rom_raw);
         @(negedge clk);
         chk(rom_ready, 1'b0);
         chk(rom_data, rom_raw);
      end
      pwm_irq_set = 1'b1;
      @(negedge clk);
      pwm_irq_set = 1'b0;
      chk(flags[2], 1'b1);
      st(6'h00, 4'h0);
      chk(flags, 4'h0);
      $display("rom and flag test done");
      conclude();
   end
endmodule : tb
